// ### hdl/rsc_defs.vh
// Purpose: constants for the reset source controller
// Assumes: 250 MHz system clock, AXI4-Lite register access
// Notes: times in their own units, cycle counts derived in the module
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH
`define RSC_CLK_KHZ 250000
`define RSC_POR_DELAY_SHORT_MS 7
`define RSC_POR_DELAY_LONG_MS 15
`define RSC_MON_SETTLE_CYC 16'h0040
`define RSC_WDT_DIV 4'hC
`define RSC_WDT_DIV_LAST 4'hB
`define RSC_ADDR_MONCTL 4'h0
`define RSC_ADDR_CAUSE 4'h4
`define RSC_ADDR_PMUMODE 4'h8
`define RSC_MONCTL_EN 7
`define RSC_MONCTL_STAT 6
`define RSC_MONCTL_OK 5
`define RSC_MONCTL_IE 3
`define RSC_CAUSE_PIN 0
`define RSC_CAUSE_PWR 1
`define RSC_CAUSE_EXT 3
`define RSC_CAUSE_SW 4
`define RSC_CAUSE_FLASH 6
`define RSC_PMU_POR_MONITOR_DISABLE 5
`define RSC_PORT_RESET 8'hFF
`define RSC_RESET_VECTOR 16'h0000
`define RSC_RESP_OKAY 2'h0
`define RSC_RESP_SLVERR 2'h2
`endif

// ### hdl/rsc_reset_source_controller.v
// Purpose: reset sequencing, reset cause flags and supply monitor control
// Assumes: comparator, pin and sleep inputs are asynchronous; core signals are on sys_clk
// Notes: registers at 0x0 monitor control, 0x4 reset cause, 0x8 power unit mode
//
// Summary of operation
// - in reset: core halted, registers at reset values, pins known, irqs and timers off
// - only power-on, power-fail and full power-on resets clear the ram valid indication
// - port latches all ones, open drain, weak pullups on during and after reset
// - power-on and supply-monitor resets drive the reset pin low throughout
// - on release: program counter zero, internal oscillator selected, fetch from zero
// - on release the watchdog is enabled, ticking at system clock divided by twelve
// - power-up holds reset until threshold passed plus a 7 or 15 ms delay
// - power-on and power-fail set the power-up cause flag and clear others; other resets clear it
// - monitor disable bit on makes every reset a full power-on reset, re-enabling it
// - power-on and power-fail resets enable and select the supply monitor
// - power-fail reset holds core and pin low until supply back above threshold
// - monitor enable and selection change only by power-on, power-fail or software
// - sleep suppresses power-fail reset; software settings come back on waking
// - early warning ok bit follows the warning comparator and can raise an irq
// - flash write or erase with monitor disabled causes a flash-error reset
// - supply-monitor reset releases without the power-on delay
// - selecting an unsettled monitor may reset the system
// - monitor enable switches the monitor; it resets only when also selected
// - early warning irq enable gates the early warning interrupt
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`include "rsc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_source_controller #(
	parameter [31:0] POR_SHORT_CYC = `RSC_POR_DELAY_SHORT_MS * `RSC_CLK_KHZ,
	parameter [31:0] POR_LONG_CYC = `RSC_POR_DELAY_LONG_MS * `RSC_CLK_KHZ
) (
	input wire sys_clk,
	input wire rst_n,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire powerOnThresholdOk,
	input wire aboveResetThreshold,
	input wire aboveWarningThreshold,
	input wire supplyHigh,
	input wire sleepMode,
	input wire resetPin_n_in,
	output wire resetPin_n_out,
	output reg resetPin_n_oe,
	input wire flashWriteReq,
	input wire otherResetReq,
	output wire coreReset,
	output reg ramValid,
	output reg [15:0] programCounterInit,
	output reg internalOscSelect,
	output reg watchdogEnable,
	output reg watchdogTick,
	output reg [7:0] portLatch,
	output reg portOpenDrain,
	output wire weakPullupEnable,
	output wire interruptsEnable,
	output wire timersEnable,
	output reg earlyWarningIrq
);
	localparam [4:0] ST_POR = 5'h01;
	localparam [4:0] ST_DELAY = 5'h02;
	localparam [4:0] ST_PFAIL = 5'h04;
	localparam [4:0] ST_RESET = 5'h08;
	localparam [4:0] ST_RUN = 5'h10;

	function [1:0] decodeAddr;
		input [3:0] addr;
		begin
			case (addr)
				`RSC_ADDR_MONCTL: decodeAddr = 2'h1;
				`RSC_ADDR_CAUSE: decodeAddr = 2'h2;
				`RSC_ADDR_PMUMODE: decodeAddr = 2'h3;
				default: decodeAddr = 2'h0;
			endcase
		end
	endfunction

	reg [4:0] sync1;
	reg [4:0] sync2;
	reg [4:0] state;
	reg [4:0] next_state;
	reg [31:0] delayCount;
	reg [15:0] settleCount;
	reg [3:0] wdtDiv;
	reg [2:0] pinMask;
	reg monitorEnable;
	reg monitorSelect;
	reg monitorDisable;
	reg irqEnable;
	reg [7:0] causeFlags;
	reg holdReset;
	reg swResetReq;
	reg awHeld;
	reg wHeld;
	reg [3:0] awAddr;
	reg [31:0] wData;
	reg [3:0] wStrb;
	wire porOkS = sync2[0];
	wire aboveResetS = sync2[1];
	wire warnOkS = sync2[2];
	wire supplyHighS = sync2[3];
	wire pinLowS = ~sync2[4];
	wire sleepS;
	reg sleep1;
	reg sleep2;
	assign sleepS = sleep2;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 5'h10;
			sync2 <= 5'h10;
			sleep1 <= 1'b0;
			sleep2 <= 1'b0;
		end else begin
			sync1 <= {resetPin_n_in, supplyHigh, aboveWarningThreshold, aboveResetThreshold, powerOnThresholdOk};
			sync2 <= sync1;
			sleep1 <= sleepMode;
			sleep2 <= sleep1;
		end
	end

	wire monitorSettled = (settleCount == `RSC_MON_SETTLE_CYC);
	// an unsettled monitor reads as below threshold
	wire supplyBelow = ~(aboveResetS & monitorSettled);
	wire monitorTrip = monitorEnable & monitorSelect & ~sleepS & supplyBelow;
	wire flashError = flashWriteReq & ~monitorEnable;
	wire pinReset = pinLowS & ~resetPin_n_oe & (pinMask == 3'h0);
	wire plainReset = swResetReq | flashError | pinReset | otherResetReq;
	wire busy = (state != ST_RUN);

	always @* begin
		next_state = state;
		case (state)
			ST_POR: begin
				if (porOkS)
					next_state = ST_DELAY;
			end
			ST_DELAY: begin
				if (!porOkS)
					next_state = ST_POR;
				else if (delayCount == 32'h0)
					next_state = ST_RUN;
			end
			ST_PFAIL: begin
				if (!porOkS && !monitorDisable)
					next_state = ST_POR;
				else if (aboveResetS)
					next_state = ST_RUN;
			end
			ST_RESET: begin
				next_state = ST_RUN;
			end
			ST_RUN: begin
				if (!porOkS && !monitorDisable)
					next_state = ST_POR;
				else if ((plainReset || monitorTrip) && monitorDisable)
					next_state = ST_POR;
				else if (monitorTrip)
					next_state = ST_PFAIL;
				else if (plainReset)
					next_state = ST_RESET;
			end
			default: begin
				next_state = ST_POR;
			end
		endcase
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_POR;
			delayCount <= 32'h0;
			causeFlags <= 8'h02;
			monitorEnable <= 1'b1;
			monitorSelect <= 1'b1;
			monitorDisable <= 1'b0;
			ramValid <= 1'b0;
		end else begin
			state <= next_state;
			if (state == ST_POR)
				delayCount <= supplyHighS ? POR_LONG_CYC : POR_SHORT_CYC;
			else if (delayCount != 32'h0)
				delayCount <= delayCount - 32'h1;
			if (next_state == ST_POR || next_state == ST_PFAIL) begin
				monitorEnable <= 1'b1;
				monitorSelect <= 1'b1;
				monitorDisable <= 1'b0;
				causeFlags <= 8'h02;
				ramValid <= 1'b0;
			end else if (state == ST_RUN && next_state == ST_RESET) begin
				causeFlags <= 8'h00;
				causeFlags[`RSC_CAUSE_PIN] <= pinReset;
				causeFlags[`RSC_CAUSE_EXT] <= otherResetReq;
				causeFlags[`RSC_CAUSE_SW] <= swResetReq;
				causeFlags[`RSC_CAUSE_FLASH] <= flashError;
			end else begin
				if (state == ST_RUN)
					ramValid <= 1'b1;
				if (awHeld && wHeld && !s_axi_bvalid && wStrb[0]) begin
					case (decodeAddr(awAddr))
						2'h1: monitorEnable <= wData[`RSC_MONCTL_EN];
						2'h2: monitorSelect <= wData[`RSC_CAUSE_PWR];
						2'h3: monitorDisable <= wData[`RSC_PMU_POR_MONITOR_DISABLE];
						default: monitorEnable <= monitorEnable;
					endcase
				end
			end
		end
	end

	// settle timer restarts whenever the monitor is switched on
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			settleCount <= 16'h0;
		else if (!monitorEnable)
			settleCount <= 16'h0;
		else if (!monitorSettled)
			settleCount <= settleCount + 16'h1;
	end

	// combined reset: asserts in the cycle a source acts, releases on an edge
	assign coreReset = busy | (state == ST_RUN && next_state != ST_RUN) | holdReset;
	assign interruptsEnable = ~coreReset;
	assign timersEnable = ~coreReset;
	assign weakPullupEnable = 1'b1;
	assign resetPin_n_out = 1'b0;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			holdReset <= 1'b1;
			resetPin_n_oe <= 1'b1;
			pinMask <= 3'h7;
			programCounterInit <= `RSC_RESET_VECTOR;
			internalOscSelect <= 1'b1;
			watchdogEnable <= 1'b0;
			wdtDiv <= 4'h0;
			watchdogTick <= 1'b0;
			portLatch <= `RSC_PORT_RESET;
			portOpenDrain <= 1'b1;
			earlyWarningIrq <= 1'b0;
		end else begin
			holdReset <= busy;
			resetPin_n_oe <= (next_state == ST_POR) | (next_state == ST_DELAY) | (next_state == ST_PFAIL);
			pinMask <= resetPin_n_oe ? 3'h7 : {pinMask[1:0], 1'b0};
			if (coreReset) begin
				programCounterInit <= `RSC_RESET_VECTOR;
				internalOscSelect <= 1'b1;
				portLatch <= `RSC_PORT_RESET;
				portOpenDrain <= 1'b1;
				watchdogEnable <= 1'b0;
				wdtDiv <= 4'h0;
			end else begin
				watchdogEnable <= 1'b1;
				wdtDiv <= (wdtDiv == `RSC_WDT_DIV_LAST) ? 4'h0 : wdtDiv + 4'h1;
			end
			watchdogTick <= watchdogEnable & (wdtDiv == `RSC_WDT_DIV_LAST);
			earlyWarningIrq <= irqEnable & ~warnOkS & ~coreReset;
		end
	end

	// register slave: address and data taken in either order
	assign s_axi_awready = ~awHeld;
	assign s_axi_wready = ~wHeld;
	assign s_axi_arready = ~s_axi_rvalid;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= 4'h0;
			wData <= 32'h0;
			wStrb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RSC_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `RSC_RESP_OKAY;
			irqEnable <= 1'b1;
			swResetReq <= 1'b0;
		end else begin
			swResetReq <= 1'b0;
			if (coreReset)
				irqEnable <= 1'b1;
			if (s_axi_awvalid && !awHeld) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !wHeld) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
			if (awHeld && wHeld && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (decodeAddr(awAddr) == 2'h0) ? `RSC_RESP_SLVERR : `RSC_RESP_OKAY;
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				if (wStrb[0] && decodeAddr(awAddr) == 2'h1)
					irqEnable <= wData[`RSC_MONCTL_IE];
				if (wStrb[0] && decodeAddr(awAddr) == 2'h2)
					swResetReq <= wData[`RSC_CAUSE_SW];
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RSC_RESP_OKAY;
				s_axi_rdata <= 32'h0;
				case (decodeAddr(s_axi_araddr))
					2'h1: s_axi_rdata[7:0] <= {monitorEnable, aboveResetS, warnOkS, 1'b0, irqEnable, 3'h0};
					2'h2: s_axi_rdata[7:0] <= causeFlags;
					2'h3: s_axi_rdata[`RSC_PMU_POR_MONITOR_DISABLE] <= monitorDisable;
					default: s_axi_rresp <= `RSC_RESP_SLVERR;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // rsc_reset_source_controller
`default_nettype wire

// ### verif/rsc_supply_model.sv
// Purpose: supply comparators and reset pin beside the controller
// Assumes: supply level given in millivolts, pin pulled up
// Notes: thresholds are plain defaults
`timescale 1ns/1ps
`default_nettype none
module rsc_supply_model #(
	parameter logic [11:0] POR_MV = 12'h5DC,
	parameter logic [11:0] RST_MV = 12'h6A4,
	parameter logic [11:0] WARN_MV = 12'h76C,
	parameter logic [11:0] HIGH_MV = 12'hBB8
) (
	input wire logic [11:0] supplyMv,
	input wire logic extReset_n,
	input wire logic resetPin_n_oe,
	output logic powerOnThresholdOk,
	output logic aboveResetThreshold,
	output logic aboveWarningThreshold,
	output logic supplyHigh,
	output logic resetPin_n_in
);
	assign powerOnThresholdOk = supplyMv > POR_MV;
	assign aboveResetThreshold = supplyMv > RST_MV;
	assign aboveWarningThreshold = supplyMv > WARN_MV;
	assign supplyHigh = supplyMv > HIGH_MV;
	// pull-up unless either side pulls low
	assign resetPin_n_in = extReset_n && !resetPin_n_oe;
endmodule // rsc_supply_model
`default_nettype wire

// ### verif/rsc_chk.sv
// Purpose: port assertions of the reset controller
// Assumes: one clock domain
// Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
module rsc_chk (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic coreReset,
	input wire logic resetPin_n_oe,
	input wire logic interruptsEnable,
	input wire logic timersEnable,
	input wire logic [7:0] portLatch,
	input wire logic portOpenDrain,
	input wire logic weakPullupEnable,
	input wire logic [15:0] programCounterInit,
	input wire logic internalOscSelect,
	input wire logic watchdogEnable,
	input wire logic watchdogTick,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_gap;
		!watchdogTick [*8] ##1 !watchdogTick [*3];
	endsequence
	a_core_halted: assert property (coreReset |-> !interruptsEnable && !timersEnable)
		else $error("core active in reset");
	a_port_known: assert property (coreReset |-> portLatch == 8'hFF && portOpenDrain && weakPullupEnable)
		else $error("port state in reset");
	a_pin_drive: assert property (resetPin_n_oe |-> coreReset)
		else $error("pin driven outside reset");
	a_release_vector: assert property ($fell(coreReset) |-> programCounterInit == 16'h0000 && internalOscSelect)
		else $error("release vector");
	a_wdog_start: assert property ($fell(coreReset) |-> ##[0:1] watchdogEnable)
		else $error("watchdog not enabled");
	a_wdog_gap: assert property (disable iff (!rst_n || coreReset) watchdogTick |=> s_gap ##1 (watchdogTick || !watchdogEnable))
		else $error("watchdog tick spacing");
	a_tick_enabled: assert property (watchdogTick |-> watchdogEnable)
		else $error("tick while disabled");
	a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_rdata_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response repeated");
endmodule // rsc_chk
bind rsc_reset_source_controller rsc_chk rsc_chk_i (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.coreReset(coreReset),
	.resetPin_n_oe(resetPin_n_oe),
	.interruptsEnable(interruptsEnable),
	.timersEnable(timersEnable),
	.portLatch(portLatch),
	.portOpenDrain(portOpenDrain),
	.weakPullupEnable(weakPullupEnable),
	.programCounterInit(programCounterInit),
	.internalOscSelect(internalOscSelect),
	.watchdogEnable(watchdogEnable),
	.watchdogTick(watchdogTick),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready)
);
`default_nettype wire

// ### verif/tb.sv
// Purpose: self-checking bench of the reset controller
// Assumes: short power-on delays of 80 and 160 cycles, longer than the monitor settle time
// Notes: reads are queued and compared by a monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic sys_clk = 1'b0;
	logic rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic powerOnThresholdOk, aboveResetThreshold, aboveWarningThreshold, supplyHigh, sleepMode;
	logic resetPin_n_in, resetPin_n_out, resetPin_n_oe, flashWriteReq, otherResetReq, coreReset, ramValid;
	logic [15:0] programCounterInit;
	logic internalOscSelect, watchdogEnable, watchdogTick, portOpenDrain, weakPullupEnable;
	logic interruptsEnable, timersEnable, earlyWarningIrq, extReset_n, pinSeen;
	logic [7:0] portLatch;
	logic [11:0] supplyMv;
	logic [17:0] x;
	int mismatches, check_count;
	logic [17:0] rq[$];
	logic [1:0] bq[$];
	rsc_reset_source_controller #(.POR_SHORT_CYC(32'd80), .POR_LONG_CYC(32'd160)) rsc_reset_source_controller_i (.*);
	rsc_supply_model rsc_supply_model_i (.*);
	always #2 sys_clk = ~sys_clk;
	task automatic stop_test;
		$display("mismatches %0d checks %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	// write: m holds the strobes; read: e and m are expected low byte and its mask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [7:0] e, m,
			input logic [1:0] r);
		int n;
		logic aw, wd, ar, b;
		if (w) bq.push_back(r);
		else rq.push_back({r, m, e});
		@(posedge sys_clk);
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, d, m[3:0]};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
		for (n = 0; n < 50; n++) begin
			@(negedge sys_clk);
			{aw, wd, ar, b} = {s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid || s_axi_rvalid};
			@(posedge sys_clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (wd) s_axi_wvalid <= 1'b0;
			if (ar) s_axi_arvalid <= 1'b0;
			if (b) break;
		end
		{s_axi_bready, s_axi_rready} <= 2'h0;
		if (n == 50) begin
			mismatches++;
			stop_test();
		end
	endtask
	task automatic waitRst(input logic v, output int n);
		n = 0;
		while (coreReset !== v && n < 400) begin
			@(negedge sys_clk);
			n++;
			pinSeen |= resetPin_n_oe;
		end
		if (n == 400) begin
			mismatches++;
			stop_test();
		end
	endtask
	always @(posedge sys_clk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			x = rq.pop_front();
			chk(s_axi_rresp === x[17:16] && (x[17] || ((s_axi_rdata ^ {24'h000000, x[7:0]})
				& {24'hFFFFFF, x[15:8]}) === 32'h00000000), "read data");
		end
		if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp === bq.pop_front(), "write response");
	end
	initial begin
		int n;
		n = $urandom(32'hDC26);
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h0;
		{sleepMode, flashWriteReq, otherResetReq, pinSeen, extReset_n} = 5'h01;
		{mismatches, check_count} = 0;
		supplyMv = 12'hCE4;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		waitRst(1'b0, n);
		chk(n >= 160 && ramValid === 1'b1, "power-on delay");
		bus(1'b0, 4'h4, 32'h0, 8'h02, 8'hFF, 2'h0);
		bus(1'b0, 4'h0, 32'h0, 8'hE8, 8'hFF, 2'h0);
		bus(1'b0, 4'hC, 32'h0, 8'h00, 8'h00, 2'h2);
		bus(1'b1, 4'hC, $urandom, 8'h00, 8'h01, 2'h2);
		bus(1'b1, 4'h0, 32'h00000008, 8'h00, 8'h01, 2'h0);
		bus(1'b1, 4'h4, 32'h00000010, 8'h00, 8'h01, 2'h0);
		pinSeen = 1'b0;
		waitRst(1'b1, n);
		waitRst(1'b0, n);
		chk(!pinSeen && ramValid === 1'b1, "software reset");
		bus(1'b0, 4'h4, 32'h0, 8'h10, 8'hFF, 2'h0);
		bus(1'b0, 4'h0, 32'h0, 8'h08, 8'h9F, 2'h0);
		@(posedge sys_clk);
		flashWriteReq <= 1'b1;
		@(posedge sys_clk);
		flashWriteReq <= 1'b0;
		waitRst(1'b1, n);
		waitRst(1'b0, n);
		bus(1'b0, 4'h4, 32'h0, 8'h40, 8'hFF, 2'h0);
		bus(1'b1, 4'h0, 32'h00000088, 8'h00, 8'h01, 2'h0);
		repeat (70) @(posedge sys_clk);
		bus(1'b1, 4'h4, 32'h00000002, 8'h00, 8'h01, 2'h0);
		bus(1'b1, 4'h0, $urandom, 8'h00, 8'h00, 2'h0);
		supplyMv <= 12'h640;
		waitRst(1'b1, n);
		repeat (10) @(negedge sys_clk);
		chk(coreReset === 1'b1 && resetPin_n_oe === 1'b1 && ramValid === 1'b0, "power fail hold");
		@(posedge sys_clk);
		supplyMv <= 12'hCE4;
		waitRst(1'b0, n);
		chk(n < 8, "power fail release");
		bus(1'b0, 4'h4, 32'h0, 8'h02, 8'h02, 2'h0);
		bus(1'b0, 4'h0, 32'h0, 8'h88, 8'h88, 2'h0);
		sleepMode <= 1'b1;
		supplyMv <= 12'h640;
		repeat (20) @(negedge sys_clk);
		chk(coreReset === 1'b0 && resetPin_n_oe === 1'b0, "sleep");
		@(posedge sys_clk);
		supplyMv <= 12'h708;
		repeat (8) @(posedge sys_clk);
		sleepMode <= 1'b0;
		repeat (8) @(negedge sys_clk);
		chk(earlyWarningIrq === 1'b1 && coreReset === 1'b0, "warning irq");
		bus(1'b0, 4'h0, 32'h0, 8'h80, 8'hA0, 2'h0);
		bus(1'b1, 4'h0, 32'h00000080, 8'h00, 8'h01, 2'h0);
		repeat (4) @(negedge sys_clk);
		chk(earlyWarningIrq === 1'b0, "irq masked");
		@(posedge sys_clk);
		extReset_n <= 1'b0;
		waitRst(1'b1, n);
		@(posedge sys_clk);
		extReset_n <= 1'b1;
		waitRst(1'b0, n);
		bus(1'b0, 4'h4, 32'h0, 8'h01, 8'hFF, 2'h0);
		bus(1'b0, 4'h0, 32'h0, 8'h88, 8'h88, 2'h0);
		bus(1'b1, 4'h8, 32'h00000020, 8'h00, 8'h01, 2'h0);
		otherResetReq <= 1'b1;
		@(posedge sys_clk);
		otherResetReq <= 1'b0;
		waitRst(1'b1, n);
		waitRst(1'b0, n);
		chk(n >= 80 && n < 160, "full power-on");
		bus(1'b0, 4'h4, 32'h0, 8'h02, 8'hFF, 2'h0);
		bus(1'b0, 4'h8, 32'h0, 8'h00, 8'h20, 2'h0);
		stop_test();
	end
endmodule // tb
`default_nettype wire
